// *** design/psq_pkg.sv ***
// Constants and types shared by the power-up and power-down sequencer.
// Overview of operation
// - Start only with supply ready and wake-level enable.
// - Enable below off level: shut down, clear faults.
// - First power on: detect pin settings over init interval.
// - Low enable current in detection, high afterwards.
// - Fixed start delay, PWM outputs tri-stated throughout.
// - Smart stage mode drives reference output during delay.
// - Soft-start slew taken from slew-select resistor code.
// - High-impedance level alternates within each slew pair.
// - Power good released once output reaches reference.
// - Serial register access refused until sequence completes.
// - Enable re-toggle skips detection, uses high current.
// - Serial registers kept across enable, lost on supply.
// - Stop switching after short delay, then tri-state.
// - Shutdown pulls power good low through open drain.
// - Brief low pulse on PWM outputs before tri-state.
// - Shutdown turns on output discharge path.
// - Smart stage mode discharges reference output at shutdown.
// - Reference-adjust output follows the voltage-ID input levels.
// - Voltage-ID ignored, output high-Z until power good.
package psq_pkg;
   localparam int CLK_PERIOD_NS       = 10;
   localparam int INIT1_TIME_NS       = 1000000;
   localparam int START_DELAY_TIME_NS = 200000;
   localparam int STOP_DELAY_TIME_NS  = 300;
   localparam int LOW_PULSE_TIME_NS   = 100;
   localparam int INIT1_CYCLES        = (INIT1_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int START_DELAY_CYCLES  = (START_DELAY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STOP_DELAY_CYCLES   = (STOP_DELAY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int LOW_PULSE_CYCLES    = (LOW_PULSE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W               = 17;
   localparam int SLEW_CODE_W         = 3;
   localparam logic [SLEW_CODE_W-1:0] SLEW_CODE_20K = 3'h0;
   localparam logic [SLEW_CODE_W-1:0] SLEW_CODE_25K = 3'h1;
   localparam logic [SLEW_CODE_W-1:0] SLEW_CODE_30K = 3'h2;
   localparam logic [SLEW_CODE_W-1:0] SLEW_CODE_35K = 3'h3;

   typedef enum logic [2:0] {
      PSQ_OFF         = 3'h0,
      PSQ_DETECT      = 3'h1,
      PSQ_WAIT_WAKE   = 3'h2,
      PSQ_START_DELAY = 3'h3,
      PSQ_SOFT_START  = 3'h4,
      PSQ_REGULATE    = 3'h5,
      PSQ_SHUT_DELAY  = 3'h6,
      PSQ_SHUT_LOW    = 3'h7
   } psq_state_t;

   typedef enum logic [1:0] {
      PSQ_SLEW_2MV = 2'h0,
      PSQ_SLEW_4MV = 2'h1,
      PSQ_SLEW_6MV = 2'h2
   } psq_slew_t;

   typedef struct packed {
      logic supply_ready;
      logic en_above_detect;
      logic en_above_wake;
      logic en_below_off;
      logic output_at_reference;
      logic duty_voltage_id_in;
   } psq_pins_t;

   typedef struct packed {
      logic [SLEW_CODE_W-1:0] slew_select_resistor;
      logic                   smart_stage_mode;
   } psq_settings_t;

   typedef struct packed {
      logic      enable_source_current;
      logic      pwm_tristate;
      logic      pwm_force_low;
      logic      switching_en;
      logic      soft_start_active;
      psq_slew_t soft_start_slew;
      logic      pwm_highz_high;
      logic      reference_level_out;
      logic      reference_discharge_en;
      logic      output_discharge_en;
      logic      power_good_out;
      logic      power_good_oe;
      logic      reference_adjust_out;
      logic      reference_adjust_oe;
      logic      serial_access_ok;
      logic      register_clear;
      logic      fault_clear;
      logic      settings_valid;
   } psq_outputs_t;
endpackage

// *** design/psq_sequencer.sv ***
// Power-up and power-down sequencer with pin-setting latch and voltage-ID buffer.
`timescale 1ns/1ps
// Walks a supply-qualified enable to regulation.
// Comparator levels arrive as plain logic levels.
// All intervals are counted in clock cycles.
// A slower clock would stretch every delay.
// The first start detects the straps once.
// Later starts by enable reuse those settings.
// Enable low winds down a switching stage.
// Supply loss outranks every other request.
module psq_sequencer
   import psq_pkg::*;
#(
   // Tests may shorten these to keep runs brief.
   parameter int INIT1_CYC       = INIT1_CYCLES,
   parameter int START_DELAY_CYC = START_DELAY_CYCLES
) (
   // Clock and synchronous reset.
   input  wire logic          clock,
   input  wire logic          rst,
   // Comparator levels and voltage-ID pin, all asynchronous to the clock.
   // Two flip-flops add two cycles of latency.
   input  wire psq_pins_t     pins_in,
   // Resistor-programmed settings seen by the pin detection front end.
   // Read once, at the end of the first detection.
   input  wire psq_settings_t settings_in,
   // Sequencer controls, each bit from a flip-flop.
   // Open-drain and buffer pins carry enables.
   output      psq_outputs_t  seq_out,
   // Settings latched at the end of the first detection.
   // Held across enable toggles and supply loss until the next detection.
   output      psq_settings_t latched_settings
);

   // Each asynchronous bit is retimed first.
   // The straps are retimed the same way.
   // Only the retimed copies reach the logic.
   // Two-flop synchroniser stages for the pins; only the second stage is read.
   psq_pins_t     pins_meta_reg;
   psq_pins_t     pins_meta_next;
   psq_pins_t     pins_sync_reg;
   psq_pins_t     pins_sync_next;
   psq_settings_t set_meta_reg;
   psq_settings_t set_meta_next;
   psq_settings_t set_sync_reg;
   psq_settings_t set_sync_next;

   // Sequencer state, interval counter and latched configuration.
   // One counter serves every timed phase.
   // Valid marks detection done since supply up.
   psq_state_t       state_reg;
   psq_state_t       state_next;
   logic [CNT_W-1:0] cnt_reg;
   logic [CNT_W-1:0] cnt_next;
   logic             valid_reg;
   logic             valid_next;
   psq_settings_t    latch_reg;
   psq_settings_t    latch_next;
   psq_outputs_t     out_reg;
   psq_outputs_t     out_next;

   // Terminal counts, sized once so the comparisons do not mix widths.
   // A phase leaves when its count is the last.
   // Sized here so comparisons share one width.
   localparam logic [CNT_W-1:0] INIT1_LAST = CNT_W'(INIT1_CYC - 1);
   localparam logic [CNT_W-1:0] START_LAST = CNT_W'(START_DELAY_CYC - 1);
   localparam logic [CNT_W-1:0] STOP_LAST  = CNT_W'(STOP_DELAY_CYCLES - 1);
   localparam logic [CNT_W-1:0] LOW_LAST   = CNT_W'(LOW_PULSE_CYCLES - 1);
   localparam logic [CNT_W-1:0] CNT_ZERO   = '0;
   localparam logic [CNT_W-1:0] CNT_ONE    = CNT_W'(1);
   // Wide enough for detection at 100 MHz.

   // Code pairs share a rate; bit 0 picks high-Z.
   // Unusual codes take the fastest ramp.
   // Map the slew-select code onto a ramp rate; codes above the table take the fastest rate.
   function automatic psq_slew_t psq_slew_decode(input logic [SLEW_CODE_W-1:0] code);
      psq_slew_t rate;
      rate = PSQ_SLEW_6MV;
      // Default keeps every path assigned.
      case (code)
         SLEW_CODE_20K, SLEW_CODE_25K: begin
            rate = PSQ_SLEW_2MV;
         end
         SLEW_CODE_30K, SLEW_CODE_35K: begin
            rate = PSQ_SLEW_4MV;
         end
         default: begin
            rate = PSQ_SLEW_6MV;
         end
      endcase
      return rate;
   endfunction

   // The stop delay still switches the phases.
   // True while the state has the phases switching, the stop delay included but not the low pulse.
   function automatic logic psq_is_switching(input psq_state_t st);
      return (st == PSQ_SOFT_START) || (st == PSQ_REGULATE) || (st == PSQ_SHUT_DELAY);
   endfunction

   // Nothing but the second stage reads the first.
   // Synchroniser next values: the first stage samples the pins, the second the first.
   always_comb begin
      pins_meta_next = pins_in;
      pins_sync_next = pins_meta_reg;
      set_meta_next  = settings_in;
      set_sync_next  = set_meta_reg;
   end

   // Synchroniser registers; cleared so no stale comparator level survives reset.
   // Retimed levels read low for two edges.
   // A low supply level holds the walk off then.
   always_ff @(posedge clock) begin
      if (rst) begin
         pins_meta_reg <= '0;
         pins_sync_reg <= '0;
         set_meta_reg  <= '0;
         set_sync_reg  <= '0;
      end else begin
         // Both stages shift on every edge.
         pins_meta_reg <= pins_meta_next;
         pins_sync_reg <= pins_sync_next;
         set_meta_reg  <= set_meta_next;
         set_sync_reg  <= set_sync_next;
      end
   end

   // Sequencer next state. Supply loss outranks everything, enable-low outranks the walk.
   // Each branch sets only what it changes.
   // A started wind-down completes unless supply is lost.
   always_comb begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      valid_next = valid_reg;
      latch_next = latch_reg;
      if (!pins_sync_reg.supply_ready) begin
         // A supply cycle clears valid, so the next start detects again.
         // Later starts then time from zero.
         state_next = PSQ_OFF;
         cnt_next   = CNT_ZERO;
         valid_next = 1'b0;
      end else if (pins_sync_reg.en_below_off && (state_reg != PSQ_OFF) &&
                   (state_reg != PSQ_SHUT_DELAY) && (state_reg != PSQ_SHUT_LOW)) begin
         // Enable low aborts any phase; only a switching stage needs the wind-down.
         // A quiet phase needs no low pulse.
         cnt_next = CNT_ZERO;
         if (psq_is_switching(state_reg)) begin
            state_next = PSQ_SHUT_DELAY;
         end else begin
            state_next = PSQ_OFF;
         end
      end else begin
         case (state_reg)
            PSQ_OFF: begin
               // First start detects; a later start goes straight to the delay.
               // Detect needs enable clear of off.
               // A restart needs only the wake level.
               cnt_next = CNT_ZERO;
               if (!valid_reg && pins_sync_reg.en_above_detect && !pins_sync_reg.en_below_off) begin
                  state_next = PSQ_DETECT;
               end else if (valid_reg && pins_sync_reg.en_above_wake) begin
                  state_next = PSQ_START_DELAY;
               end
            end
            PSQ_DETECT: begin
               // Settings are captured at the end of the nominal detection interval.
               // Latched from the retimed straps.
               // An abort leaves valid clear.
               cnt_next = cnt_reg + CNT_ONE;
               if (cnt_reg == INIT1_LAST) begin
                  state_next = PSQ_WAIT_WAKE;
                  latch_next = set_sync_reg;
                  valid_next = 1'b1;
                  cnt_next   = CNT_ZERO;
               end
            end
            PSQ_WAIT_WAKE: begin
               // The higher enable current now lifts enable towards the wake level.
               // Wake may take a while to build.
               cnt_next = CNT_ZERO;
               if (pins_sync_reg.en_above_wake) begin
                  state_next = PSQ_START_DELAY;
               end
            end
            PSQ_START_DELAY: begin
               // Fixed delay before the ramp starts.
               // Pins float; reference is driven in smart mode.
               cnt_next = cnt_reg + CNT_ONE;
               if (cnt_reg == START_LAST) begin
                  state_next = PSQ_SOFT_START;
                  cnt_next   = CNT_ZERO;
               end
            end
            PSQ_SOFT_START: begin
               // No timeout here: fault handling for a stalled ramp lives elsewhere.
               // A stalled ramp is seen elsewhere.
               if (pins_sync_reg.output_at_reference) begin
                  state_next = PSQ_REGULATE;
               end
            end
            PSQ_REGULATE: begin
               // Left only via the checks above.
               state_next = PSQ_REGULATE;
            end
            PSQ_SHUT_DELAY: begin
               // Phases keep switching for the short stop delay.
               // Power good is low, drain is on.
               // Enable low is ignored here.
               cnt_next = cnt_reg + CNT_ONE;
               if (cnt_reg == STOP_LAST) begin
                  state_next = PSQ_SHUT_LOW;
                  cnt_next   = CNT_ZERO;
               end
            end
            PSQ_SHUT_LOW: begin
               // Low pulse keeps both switches off before the pins float.
               // This avoids shoot-through at stop.
               // Width only has to beat driver delay.
               cnt_next = cnt_reg + CNT_ONE;
               if (cnt_reg == LOW_LAST) begin
                  state_next = PSQ_OFF;
                  cnt_next   = CNT_ZERO;
               end
            end
            default: begin
               // An unused code recovers to off.
               state_next = PSQ_OFF;
               cnt_next   = CNT_ZERO;
            end
         endcase
      end
   end

   // Output next values, derived from the next state so each output leaves a flip-flop.
   // A wider cone buys one cycle less lag.
   // The all-zero default covers every path.
   always_comb begin
      out_next                        = '0;
      out_next.settings_valid         = valid_next;
      // Low current only until the settings have been detected once.
      // Low current keeps enable slow for detection.
      out_next.enable_source_current  = valid_next;
      out_next.switching_en           = psq_is_switching(state_next);
      // Pins float in every state except switching and the low pulse.
      // Drivers see their high-Z level meanwhile.
      out_next.pwm_tristate           = !psq_is_switching(state_next) && (state_next != PSQ_SHUT_LOW);
      out_next.pwm_force_low          = (state_next == PSQ_SHUT_LOW);
      out_next.soft_start_active      = (state_next == PSQ_SOFT_START);
      // Ramp rate comes only from the kept code.
      out_next.soft_start_slew        = psq_slew_decode(latch_next.slew_select_resistor);
      // Even codes in each pair pick the higher high-impedance level.
      // Kept code applies even while pins float.
      out_next.pwm_highz_high         = !latch_next.slew_select_resistor[0];
      // Smart mode only, start delay only.
      out_next.reference_level_out    = latch_next.smart_stage_mode && (state_next == PSQ_START_DELAY);
      // Discharge paths stay on while enable is low, not only during the wind-down.
      // Stops a leak lifting the output again.
      out_next.output_discharge_en    = (state_next == PSQ_SHUT_DELAY) || (state_next == PSQ_SHUT_LOW) ||
                                        ((state_next == PSQ_OFF) && pins_sync_reg.en_below_off);
      out_next.reference_discharge_en = latch_next.smart_stage_mode && out_next.output_discharge_en;
      // In smart mode both drains run together.
      // Open drain: the level driven is always low, the enable pulls the line.
      // Never driven high, so a shared rail is safe.
      out_next.power_good_out         = 1'b0;
      out_next.power_good_oe          = (state_next != PSQ_REGULATE);
      // Release lets the pull-up raise power good.
      // Voltage-ID buffer follows the synchronised input only after power good.
      // Retiming delays each edge two cycles.
      out_next.reference_adjust_oe    = (state_next == PSQ_REGULATE);
      out_next.reference_adjust_out   = (state_next == PSQ_REGULATE) && pins_sync_reg.duty_voltage_id_in;
      out_next.serial_access_ok       = (state_next == PSQ_REGULATE);
      // Serial access waits for power good.
      out_next.register_clear         = !pins_sync_reg.supply_ready;
      // Only supply loss clears the registers.
      // One-cycle fault clear on each entry into shutdown or off from an active state.
      // A supply loss clears faults anyway.
      out_next.fault_clear            = pins_sync_reg.en_below_off && (state_reg != PSQ_OFF) &&
                                        (state_reg != PSQ_SHUT_DELAY) && (state_reg != PSQ_SHUT_LOW);
   end

   // Sequencer and output registers. Reset leaves power good pulled low and pins floating.
   // Reset is synchronous and settles all.
   // Outputs reset to the off-state image.
   always_ff @(posedge clock) begin
      if (rst) begin
         state_reg                     <= PSQ_OFF;
         cnt_reg                       <= CNT_ZERO;
         valid_reg                     <= 1'b0;
         latch_reg                     <= '0;
         out_reg                       <= '0;
         out_reg.pwm_tristate          <= 1'b1;
         out_reg.power_good_oe         <= 1'b1;
         out_reg.register_clear        <= 1'b1;
      end else begin
         // No enable: every edge loads.
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
         valid_reg <= valid_next;
         latch_reg <= latch_next;
         out_reg   <= out_next;
      end
   end

   // Ports come straight from registers.
   // No logic between registers and ports.
   assign seq_out          = out_reg;
   assign latched_settings = latch_reg;

endmodule

// *** test/psq_checker.sv ***
// Assertion checker bound to the power sequencer's ports.
`timescale 1ns/1ps
module psq_checker
   import psq_pkg::*;
#(
   parameter int INIT1_CYC       = INIT1_CYCLES,
   parameter int START_DELAY_CYC = START_DELAY_CYCLES
) (
   // Clock and reset.
   input wire logic          clock,
   input wire logic          rst,
   // Watched pins and outputs.
   input wire psq_pins_t     pins_in,
   input wire psq_settings_t settings_in,
   input wire psq_outputs_t  seq_out,
   input wire psq_settings_t latched_settings
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   logic [CNT_W-1:0] ref_cnt_reg;  // Length of the current start-delay drive.
   logic [CNT_W-1:0] ref_cnt_next; // Next value of that length.
   // Counts cycles of reference drive; a run cut short shows as a low count.
   always_comb begin
      ref_cnt_next = seq_out.reference_level_out ? ref_cnt_reg + 1'b1 : '0;
   end
   // Registers the count.
   always_ff @(posedge clock) begin
      ref_cnt_reg <= rst ? '0 : ref_cnt_next;
   end
   // Slew expected from the latched resistor code; codes past the table clip to the top rate.
   function automatic psq_slew_t slew_of(input logic [SLEW_CODE_W-1:0] code);
      return (code >= 3'h4) ? PSQ_SLEW_6MV : psq_slew_t'(code[2:1]);
   endfunction
   sequence s_stop;
      seq_out.switching_en ##29 seq_out.switching_en;
   endsequence
   sequence s_low;
      (seq_out.pwm_force_low && !seq_out.switching_en) [*5] ##1 seq_out.pwm_force_low [*5]
         ##1 (seq_out.pwm_tristate && !seq_out.pwm_force_low);
   endsequence
   a_start_len: assert property ($rose(seq_out.soft_start_active) && latched_settings.smart_stage_mode |->
      ref_cnt_reg == START_DELAY_CYC) else $error("start delay length wrong");
   a_delay_hiz: assert property (seq_out.reference_level_out |-> seq_out.pwm_tristate &&
      !seq_out.switching_en && latched_settings.smart_stage_mode) else $error("drive during start delay");
   a_shut_order: assert property ($rose(seq_out.fault_clear) && seq_out.switching_en |->
      s_stop ##1 s_low) else $error("shutdown order wrong");
   a_power_good_out_shut: assert property (seq_out.fault_clear |-> seq_out.power_good_oe &&
      !seq_out.power_good_out && seq_out.output_discharge_en) else $error("shutdown outputs wrong");
   a_ref_drain: assert property (seq_out.output_discharge_en && seq_out.settings_valid &&
      latched_settings.smart_stage_mode |-> seq_out.reference_discharge_en) else $error("no reference drain");
   a_vid_follow: assert property (seq_out.reference_adjust_oe |->
      seq_out.reference_adjust_out == $past(pins_in.duty_voltage_id_in, 3)) else $error("adjust output wrong");
   a_adjust_hiz: assert property (seq_out.power_good_oe |-> !seq_out.reference_adjust_oe &&
      !seq_out.serial_access_ok) else $error("adjust or serial active early");
   a_power_good_out_rise: assert property ($fell(seq_out.power_good_oe) |-> $past(seq_out.soft_start_active) &&
      $past(pins_in.output_at_reference, 3)) else $error("power good released early");
   a_slew_map: assert property (seq_out.soft_start_active |-> seq_out.soft_start_slew ==
      slew_of(latched_settings.slew_select_resistor) && seq_out.pwm_highz_high ==
      !latched_settings.slew_select_resistor[0]) else $error("slew or high-z level wrong");
   a_current_sel: assert property (seq_out.enable_source_current == seq_out.settings_valid)
      else $error("enable current wrong");
   a_supply_loss: assert property (!$past(pins_in.supply_ready, 3) && !$past(pins_in.supply_ready, 4) |->
      seq_out.register_clear && !seq_out.settings_valid && !seq_out.switching_en) else $error("supply loss");
endmodule
bind psq_sequencer psq_checker #(.INIT1_CYC(INIT1_CYC), .START_DELAY_CYC(START_DELAY_CYC)) psq_checker_inst (
   .clock(clock), .rst(rst), .pins_in(pins_in), .settings_in(settings_in),
   .seq_out(seq_out), .latched_settings(latched_settings));

// *** test/psq_far_side.sv ***
// Far-side model: output stage ramp, voltage-ID source and driver enable.
`timescale 1ns/1ps
module psq_far_side
   import psq_pkg::*;
(
   // Clock, sequencer outputs and controller wake level.
   input  wire logic         clock,
   input  wire psq_outputs_t seq_out,
   input  wire logic         en_wake,
   // Ramp length in cycles: small is a prompt stage, large a slow one.
   input  wire logic [7:0]   ramp_cycles,
   // Lines back to the sequencer and the driver enable.
   output logic              output_at_reference,
   output logic              duty_voltage_id_in,
   output logic              driver_en
);
   logic [7:0] ramp_reg = 8'h00; // Cycles of switching so far.
   logic [2:0] vid_reg  = 3'h0;  // Voltage-ID pattern phase.
   logic [3:0] drv_reg  = 4'h0;  // Driver enable delay line.
   // The output only reaches its target while the phases switch; the source never stops toggling.
   always @(negedge clock) begin
      ramp_reg <= !seq_out.switching_en ? 8'h00 : (ramp_reg == 8'hff) ? ramp_reg : ramp_reg + 8'h01;
      vid_reg  <= vid_reg + 3'h1;
      drv_reg  <= {drv_reg[2:0], en_wake};
   end
   assign output_at_reference = seq_out.switching_en && (ramp_reg >= ramp_cycles);
   assign duty_voltage_id_in  = vid_reg[2] ^ vid_reg[0];
   assign driver_en           = drv_reg[3];
endmodule

// *** test/tb_top.sv ***
// Self-checking testbench for the power sequencer.
`timescale 1ns/1ps
module tb_top;
   import psq_pkg::*;
   localparam int INIT1_T = 20; // Shortened detection time.
   localparam int DELAY_T = 10; // Shortened start delay.
   logic          clock = 1'b0;
   logic          rst = 1'b1;
   logic          supply = 1'b0;
   logic          en_det = 1'b0;
   logic          en_wake = 1'b0;
   logic          en_off = 1'b1;
   logic [7:0]    ramp_cycles = 8'h03;
   psq_settings_t settings = '0;
   logic          at_ref;
   logic          vid;
   psq_pins_t     pins;
   psq_outputs_t  seq_out;
   psq_settings_t latched;
   psq_settings_t kept;
   int            n_errors = 0;
   int            n_compared = 0;
   int            n;
   assign pins = {supply, en_det, en_wake, en_off, at_ref, vid};
   psq_sequencer #(.INIT1_CYC(INIT1_T), .START_DELAY_CYC(DELAY_T)) psq_sequencer_inst (.clock(clock), .rst(rst),
      .pins_in(pins), .settings_in(settings), .seq_out(seq_out), .latched_settings(latched));
   psq_far_side psq_far_side_inst (.clock(clock), .seq_out(seq_out), .en_wake(en_wake), .ramp_cycles(ramp_cycles),
      .output_at_reference(at_ref), .duty_voltage_id_in(vid), .driver_en());
   // Free-running 100 MHz clock.
   initial begin
      forever #5 clock = ~clock;
   end
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic conclude();
      if (n_errors == 0 && n_compared > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // Status bit picked by index, so one bounded wait serves every event.
   function automatic logic pick(input int k);
      case (k)
         0: return seq_out.soft_start_active;
         1: return !seq_out.power_good_oe;
         2: return seq_out.settings_valid;
         3: return seq_out.fault_clear;
         4: return seq_out.pwm_force_low;
         default: return seq_out.pwm_tristate && !seq_out.pwm_force_low;
      endcase
   endfunction
   // Counts falling edges until the event; a hang counts as a mismatch and ends the run.
   task automatic wait_for(input int k, output int cnt);
      cnt = 0;
      while (pick(k) !== 1'b1) begin
         @(negedge clock);
         cnt++;
         if (cnt > 300) begin
            n_errors++;
            conclude();
         end
      end
   endtask
   // Supply cycle, pin detection, wake, soft start and power good.
   task automatic power_up_first(input logic [2:0] code, input logic smart);
      supply = 1'b0;
      repeat (6) @(negedge clock);
      check("register_clear", seq_out.register_clear, 8'h01);
      supply = 1'b1;
      settings = {code, smart};
      en_off = 1'b0;
      en_det = 1'b1;
      repeat (6) @(negedge clock);
      check("detect current", seq_out.enable_source_current, 8'h00);
      wait_for(2, n);
      check("detect length", 8'(n + 6), 8'(INIT1_T + 3));
      check("latched", latched, {code, smart});
      check("run current", seq_out.enable_source_current, 8'h01);
      en_wake = 1'b1;
      wait_for(0, n);
      check("slew", seq_out.soft_start_slew, (code >= 3'h4) ? 8'h02 : 8'(code >> 1));
      check("highz level", seq_out.pwm_highz_high, 8'(!code[0]));
      check("serial early", seq_out.serial_access_ok, 8'h00);
      wait_for(1, n);
      check("serial", seq_out.serial_access_ok, 8'h01);
      check("adjust oe", seq_out.reference_adjust_oe, 8'h01);
   endtask
   // Enable low from regulation: stop delay, low pulse, tri-state.
   task automatic shut_down();
      en_off = 1'b1;
      en_wake = 1'b0;
      en_det = 1'b0;
      wait_for(3, n);
      check("power_good_out pulled", seq_out.power_good_oe, 8'h01);
      check("discharge", seq_out.output_discharge_en, 8'h01);
      wait_for(4, n);
      check("stop delay", 8'(n), 8'd30);
      wait_for(5, n);
      check("low pulse", 8'(n), 8'd10);
   endtask
   // Power-up by enable re-toggle with changed resistors and a slow output stage.
   task automatic retoggle();
      kept = latched;
      settings = ~kept;
      ramp_cycles = 8'd40;
      en_off = 1'b0;
      en_det = 1'b1;
      en_wake = 1'b1;
      @(negedge clock);
      check("retoggle current", seq_out.enable_source_current, 8'h01);
      wait_for(0, n);
      check("start delay", 8'(n + 1), 8'(DELAY_T + 3));
      check("kept settings", latched, kept);
      wait_for(1, n);
      check("regulating", seq_out.serial_access_ok, 8'h01);
   endtask
   // Enable low inside the start delay goes straight to off.
   task automatic abort_delay();
      en_off = 1'b0;
      en_wake = 1'b1;
      repeat (7) @(negedge clock);
      check("delay tristate", {seq_out.pwm_tristate, seq_out.switching_en}, 8'h02);
      en_off = 1'b1;
      en_wake = 1'b0;
      repeat (6) @(negedge clock);
      check("abort", {seq_out.pwm_force_low, seq_out.switching_en, seq_out.output_discharge_en}, 8'h01);
   endtask
   // Supply lost while regulating; wake alone must not restart.
   task automatic supply_loss();
      retoggle();
      supply = 1'b0;
      repeat (12) @(negedge clock);
      check("supply loss", {seq_out.register_clear, seq_out.settings_valid, seq_out.switching_en}, 8'h04);
   endtask
   // Reset, then each scenario in turn; slew codes 0 to 5 each go through a full first power-on.
   initial begin
      repeat (16) @(posedge clock);
      @(negedge clock);
      rst = 1'b0;
      for (int c = 0; c < 6; c++) begin
         power_up_first(3'(c), c[0]);
         shut_down();
      end
      retoggle();
      shut_down();
      abort_delay();
      supply_loss();
      conclude();
   end
endmodule
